// *** arsc_defines.svh ***
`ifndef ARSC_DEFINES_SVH
`define ARSC_DEFINES_SVH

`define ARSC_ADDR_W 4
`define ARSC_DATA_W 32
`define ARSC_SAMPLE_W 24
`define ARSC_PHASE_W 8
`define ARSC_CNT_W 8
`define ARSC_SETTLE_W 4

`define ARSC_REG_CONFIG 4'h0
`define ARSC_REG_PHASE 4'h1
`define ARSC_REG_DATA0 4'h2
`define ARSC_REG_DATA1 4'h3
`define ARSC_REG_STATUS 4'h4

`define ARSC_CFG_SRST_LSB 0
`define ARSC_CFG_SHDN_LSB 2
`define ARSC_CFG_EXTREF_BIT 4
`define ARSC_CFG_EXTCLK_BIT 5
`define ARSC_CFG_BSEN_LSB 6

`define ARSC_PHASE_RESET 8'h00
`define ARSC_INIT_SETTLE 4'h3
`define ARSC_ZERO_PATTERN 4'h3
`define ARSC_DR_DIV 256
`define ARSC_SINC_SETTLE 3

`endif

// *** arsc_pkg.sv ***
`include "arsc_defines.svh"

package arsc_pkg;

  typedef struct packed {
    logic rst_n_s1;
    logic rst_n_s2;
    logic por_s1;
    logic por_s2;
    logic [1:0] soft_rst;
    logic [1:0] shutdown;
    logic [1:0] bs_en;
    logic ext_ref;
    logic ext_clk;
    logic [`ARSC_PHASE_W-1:0] phase;
    logic [1:0][`ARSC_SAMPLE_W-1:0] data;
    logic [`ARSC_CNT_W-1:0] cnt;
    logic [1:0][`ARSC_SETTLE_W-1:0] settle;
    logic [1:0][1:0] pat;
    logic [1:0] drdy;
    logic [1:0] mod_out;
    logic [1:0] mod_oe;
    logic [1:0] bias_en;
    logic core_clk_en;
    logic input_clk_en;
    logic ref_en;
    logic supply_mon_en;
    logic spi_in_reset;
    logic comp_reset;
    logic [`ARSC_DATA_W-1:0] rd_data;
  } arsc_state_t;

endpackage

// *** arsc_reset_ctrl.sv ***
// What this block does
// - Channel soft reset only from its config bit; converter runs, output zero
// - Soft reset clears only that channel's data register
// - Channels soft reset independently; config left unchanged
// - No data-ready pulse from a channel in soft reset
// - Soft reset with bitstream enabled repeats 0011 on that pin
// - Leaving soft reset keeps phase delay, resyncs to running channel
// - One channel in soft reset keeps clock running for resync
// - Both soft reset: core clock stops, input clock stays, auto restore
// - Hard reset pin or power-on reset restores defaults, clears data
// - Hard reset tristates bitstreams and forces comparators to 0011
// - Hard reset holds serial interface in reset, no answers
// - Leaving shutdown enables biases; first data-ready after sinc settling
// - Channels shut down independently via config bit; config unchanged
// - Shutdown flushes channel data to zero, no data-ready pulses
// - Shutdown with bitstream enabled repeats 0011 on that pin
// - Leaving shutdown keeps phase delay, resyncs to running channel
// - Both shut down: input and core clocks gated until one resumes
// - Shutdown 11 with both external selects enters full shutdown
// - Full shutdown leaves only the serial interface and any enabled bitstream pin active
// - Any of those bits cleared restarts supply monitoring
// - Leaving full shutdown acts as power-on reset, ready after three periods
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "arsc_defines.svh"

module arsc_reset_ctrl #(
  parameter int DR_DIV = `ARSC_DR_DIV,
  parameter int SINC_SETTLE = `ARSC_SINC_SETTLE
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic hard_reset_n,
  input wire logic por_req,
  input wire logic [`ARSC_ADDR_W-1:0] addr,
  input wire logic [`ARSC_DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [`ARSC_DATA_W-1:0] rd_data,
  input wire logic [1:0] conv_valid,
  input wire logic [`ARSC_SAMPLE_W-1:0] conv_data_0,
  input wire logic [`ARSC_SAMPLE_W-1:0] conv_data_1,
  input wire logic [1:0] mod_bit_in,
  output logic [1:0] data_ready,
  output logic [1:0] modulator_bitstream_out,
  output logic [1:0] modulator_bitstream_oe,
  output logic [1:0] analog_bias_en,
  output logic core_clk_en,
  output logic input_clk_en,
  output logic internal_ref_en,
  output logic supply_monitor_en,
  output logic serial_if_reset,
  output logic comparator_reset
);

  arsc_pkg::arsc_state_t s;
  arsc_pkg::arsc_state_t next_s;

  logic hard;
  logic full;
  logic [1:0] active;
  logic [1:0] tick;
  logic leave_full;

  // Read msb first so the pin shows 0, 0, 1, 1
  localparam logic [3:0] ZERO_PAT = `ARSC_ZERO_PATTERN;

  function automatic logic [`ARSC_DATA_W-1:0] cfg_word(
    input logic [1:0] srst, input logic [1:0] shdn, input logic eref,
    input logic eclk, input logic [1:0] bsen);
    cfg_word = '0;
    cfg_word[`ARSC_CFG_SRST_LSB +: 2] = srst;
    cfg_word[`ARSC_CFG_SHDN_LSB +: 2] = shdn;
    cfg_word[`ARSC_CFG_EXTREF_BIT] = eref;
    cfg_word[`ARSC_CFG_EXTCLK_BIT] = eclk;
    cfg_word[`ARSC_CFG_BSEN_LSB +: 2] = bsen;
  endfunction

  function automatic logic is_full(input logic [1:0] shdn,
    input logic eref, input logic eclk);
    is_full = (&shdn) && eref && eclk;
  endfunction

  // Level sensitive; synchroniser second stage is the only reader
  assign hard = !s.rst_n_s2 || s.por_s2;
  assign full = is_full(s.shutdown, s.ext_ref, s.ext_clk);
  assign active = ~s.soft_rst & ~s.shutdown;
  // Phase beyond DR_DIV-1 never ticks channel 1
  assign tick[0] = s.core_clk_en && (s.cnt == `ARSC_CNT_W'(0));
  assign tick[1] = s.core_clk_en && (s.cnt == s.phase);

  always_comb begin
    next_s = s;
    next_s.rst_n_s1 = hard_reset_n;
    next_s.rst_n_s2 = s.rst_n_s1;
    next_s.por_s1 = por_req;
    next_s.por_s2 = s.por_s1;
    next_s.drdy = 2'h0;
    next_s.rd_data = '0;

    // Shared rate counter keeps running while any channel converts
    if (s.core_clk_en) begin
      if (s.cnt == `ARSC_CNT_W'(DR_DIV - 1)) begin
        next_s.cnt = '0;
      end else begin
        next_s.cnt = s.cnt + `ARSC_CNT_W'(1);
      end
    end

    for (int c = 0; c < 2; c++) begin
      if (active[c]) begin
        next_s.pat[c] = 2'h0;
        next_s.mod_out[c] = s.bs_en[c] && mod_bit_in[c];
        if (conv_valid[c]) begin
          next_s.data[c] = (c == 0) ? conv_data_0 : conv_data_1;
        end
        if (tick[c]) begin
          if (s.settle[c] != '0) begin
            next_s.settle[c] = s.settle[c] - `ARSC_SETTLE_W'(1);
          end else begin
            next_s.drdy[c] = 1'b1;
          end
        end
      end else begin
        next_s.data[c] = '0;
        next_s.settle[c] = `ARSC_SETTLE_W'(SINC_SETTLE);
        next_s.pat[c] = s.pat[c] + 2'h1;
        next_s.mod_out[c] = s.bs_en[c] &&
          ZERO_PAT[2'h3 - s.pat[c]];
      end
    end
    next_s.mod_oe = s.bs_en;

    // Gating follows the live mode; one cycle behind the config
    next_s.core_clk_en = |active;
    next_s.input_clk_en = !(&s.shutdown);
    next_s.bias_en = ~s.shutdown;
    next_s.ref_en = !s.ext_ref && !full;
    next_s.supply_mon_en = !full;
    next_s.spi_in_reset = 1'b0;
    next_s.comp_reset = 1'b0;

    if (wr_en) begin
      unique case (addr)
        `ARSC_REG_CONFIG: begin
          next_s.soft_rst = wr_data[`ARSC_CFG_SRST_LSB +: 2];
          next_s.shutdown = wr_data[`ARSC_CFG_SHDN_LSB +: 2];
          next_s.ext_ref = wr_data[`ARSC_CFG_EXTREF_BIT];
          next_s.ext_clk = wr_data[`ARSC_CFG_EXTCLK_BIT];
          next_s.bs_en = wr_data[`ARSC_CFG_BSEN_LSB +: 2];
        end
        `ARSC_REG_PHASE: next_s.phase = wr_data[`ARSC_PHASE_W-1:0];
        default: ;
      endcase
    end

    if (rd_en) begin
      unique case (addr)
        `ARSC_REG_CONFIG: next_s.rd_data = cfg_word(s.soft_rst,
          s.shutdown, s.ext_ref, s.ext_clk, s.bs_en);
        `ARSC_REG_PHASE: next_s.rd_data = `ARSC_DATA_W'(s.phase);
        `ARSC_REG_DATA0: next_s.rd_data = `ARSC_DATA_W'(s.data[0]);
        `ARSC_REG_DATA1: next_s.rd_data = `ARSC_DATA_W'(s.data[1]);
        `ARSC_REG_STATUS: next_s.rd_data = `ARSC_DATA_W'(
          {s.input_clk_en, full, s.core_clk_en, active});
        default: next_s.rd_data = '0;
      endcase
    end

    // Leaving full shutdown is an internal power-on reset
    leave_full = full && !is_full(next_s.shutdown, next_s.ext_ref,
      next_s.ext_clk);
    if (leave_full) begin
      next_s.soft_rst = 2'h0;
      next_s.shutdown = 2'h0;
      next_s.ext_ref = 1'b0;
      next_s.ext_clk = 1'b0;
      next_s.bs_en = 2'h0;
      next_s.phase = `ARSC_PHASE_RESET;
      next_s.data = '0;
      next_s.cnt = '0;
      next_s.settle = {2{`ARSC_INIT_SETTLE}};
      next_s.supply_mon_en = 1'b1;
    end

    // Hard reset wins over everything, bus included
    if (hard) begin
      next_s.soft_rst = 2'h0;
      next_s.shutdown = 2'h0;
      next_s.ext_ref = 1'b0;
      next_s.ext_clk = 1'b0;
      next_s.bs_en = 2'h0;
      next_s.phase = `ARSC_PHASE_RESET;
      next_s.data = '0;
      next_s.cnt = '0;
      next_s.settle = {2{`ARSC_INIT_SETTLE}};
      next_s.pat = '0;
      next_s.drdy = 2'h0;
      next_s.mod_out = 2'h0;
      next_s.mod_oe = 2'h0;
      next_s.bias_en = 2'h3;
      next_s.core_clk_en = 1'b0;
      next_s.input_clk_en = 1'b1;
      next_s.ref_en = 1'b1;
      next_s.supply_mon_en = 1'b1;
      next_s.spi_in_reset = 1'b1;
      next_s.comp_reset = 1'b1;
      next_s.rd_data = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rd_data = s.rd_data;
  assign data_ready = s.drdy;
  assign modulator_bitstream_out = s.mod_out;
  assign modulator_bitstream_oe = s.mod_oe;
  assign analog_bias_en = s.bias_en;
  assign core_clk_en = s.core_clk_en;
  assign input_clk_en = s.input_clk_en;
  assign internal_ref_en = s.ref_en;
  assign supply_monitor_en = s.supply_mon_en;
  assign serial_if_reset = s.spi_in_reset;
  assign comparator_reset = s.comp_reset;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  chk_srst_no_ready: assert property (
    s.soft_rst[0] |=> !s.drdy[0] && s.data[0] == '0)
    else $error("ready or data from channel 0 in soft reset");

  chk_shdn_flush: assert property (
    s.shutdown[1] |=> !s.drdy[1] && s.data[1] == '0)
    else $error("ready or data from channel 1 in shutdown");

  chk_zero_pattern: assert property (
    (!hard && !active[0] && s.bs_en[0] && s.pat[0] == 2'h0)
      |=> !s.mod_out[0] ##1 (!s.mod_out[0] || active[0]))
    else $error("zero bitstream pattern wrong");

  chk_hard_hiz: assert property (
    hard |=> s.mod_oe == 2'h0 && s.comp_reset)
    else $error("bitstream driven during hard reset");

  chk_hard_serial: assert property (
    hard && rd_en |=> s.spi_in_reset && s.rd_data == '0)
    else $error("serial interface answered in hard reset");

  chk_core_gate: assert property (
    (!hard && (&s.soft_rst) && !(&s.shutdown))
      |=> !s.core_clk_en && s.input_clk_en)
    else $error("core clock gating wrong in soft reset");

  chk_input_gate: assert property (
    (!hard && (&s.shutdown)) |=> !s.input_clk_en && !s.core_clk_en)
    else $error("clocks not gated with both channels shut down");

  chk_full_monitor: assert property (
    (!hard && full) |=> !s.ref_en && s.supply_mon_en == !full)
    else $error("monitor or reference alive in full shutdown");

  chk_full_exit: assert property (
    (!hard && leave_full) |=> s.shutdown == 2'h0 && s.supply_mon_en &&
      s.settle[0] == `ARSC_INIT_SETTLE && s.phase == `ARSC_PHASE_RESET)
    else $error("full shutdown exit did not reinitialise");

  chk_settle_load: assert property (
    (!hard && !active[1])
      |=> s.settle[1] == ($past(leave_full) ? `ARSC_INIT_SETTLE :
      `ARSC_SETTLE_W'(SINC_SETTLE)))
    else $error("settling count not reloaded");

  chk_phase_ready: assert property (
    s.drdy[1] |-> $past(s.cnt) == $past(s.phase))
    else $error("channel 1 ready off its phase slot");

  chk_srst_clear1: assert property (
    s.soft_rst[1] |=> !s.drdy[1] && s.data[1] == '0)
    else $error("ready or data from channel 1 in soft reset");

  chk_shdn_flush0: assert property (
    s.shutdown[0] |=> !s.drdy[0] && s.data[0] == '0)
    else $error("ready or data from channel 0 in shutdown");

  // Only the affected channel loses its data
  chk_data_hold: assert property (
    (!hard && !leave_full && active[1] && !conv_valid[1])
      |=> $stable(s.data[1]))
    else $error("data of a running channel changed");

  chk_mode_write: assert property (
    (!hard && !(wr_en && addr == `ARSC_REG_CONFIG))
      |=> $stable(s.soft_rst) && $stable(s.shutdown))
    else $error("mode bits changed without a config write");

  chk_cfg_kept: assert property (
    (!hard && !wr_en) |=> $stable(s.phase) && $stable(s.bs_en) &&
      $stable(s.ext_ref) && $stable(s.ext_clk))
    else $error("configuration changed without a write");

  chk_zero_ones0: assert property (
    (!hard && !active[0] && s.bs_en[0] && s.pat[0] == 2'h3)
      |=> s.mod_out[0])
    else $error("zero bitstream lost its ones on channel 0");

  chk_zero_ones1: assert property (
    (!hard && !active[1] && s.bs_en[1] && s.pat[1] == 2'h2)
      |=> s.mod_out[1])
    else $error("zero bitstream lost its ones on channel 1");

  chk_pin_enable: assert property (
    !hard |=> s.mod_oe == $past(s.bs_en))
    else $error("bitstream pin enable does not follow its bit");

  chk_settle_count: assert property (
    (!hard && active[0] && tick[0] && s.settle[0] != '0)
      |=> !s.drdy[0] &&
      s.settle[0] == $past(s.settle[0]) - `ARSC_SETTLE_W'(1))
    else $error("ready before the sinc filter settled");

  chk_ready_settled: assert property (
    (!hard && active[0] && tick[0] && s.settle[0] == '0) |=> s.drdy[0])
    else $error("no ready once settled");

  chk_bias_follow: assert property (
    !hard |=> s.bias_en == ~$past(s.shutdown))
    else $error("bias enable does not follow shutdown");

  chk_hard_defaults: assert property (
    hard |=> s.soft_rst == 2'h0 && s.shutdown == 2'h0 && s.data == '0 &&
      s.phase == `ARSC_PHASE_RESET && s.bias_en == 2'h3)
    else $error("hard reset left state behind");

  // Input structure keeps its clock so the inputs stay biased
  chk_hard_clocks: assert property (
    hard |=> s.input_clk_en && !s.core_clk_en && s.supply_mon_en)
    else $error("clocks or monitors wrong in hard reset");

  chk_hard_release: assert property (
    (!hard && $past(hard)) |=> !s.spi_in_reset && !s.comp_reset)
    else $error("interface still held after hard reset release");

  chk_clock_runs: assert property (
    (!hard && active != 2'h0) |=> s.core_clk_en)
    else $error("core clock stopped with a channel converting");

  chk_rate_count: assert property (
    (!hard && !leave_full && s.core_clk_en) |=> !$stable(s.cnt))
    else $error("rate counter stalled with the clock running");

  chk_ch0_slot: assert property (
    s.drdy[0] |-> $past(s.cnt) == `ARSC_CNT_W'(0))
    else $error("channel 0 ready off its slot");

  chk_ref_follow: assert property (
    !hard |=> s.ref_en == $past(!s.ext_ref && !full))
    else $error("internal reference enable wrong");

  // The serial port must still answer with everything else off
  chk_full_serial: assert property (
    (!hard && full && rd_en && addr == `ARSC_REG_CONFIG)
      |=> !s.spi_in_reset &&
      s.rd_data[`ARSC_CFG_SHDN_LSB +: 2] == 2'h3)
    else $error("serial interface silent in full shutdown");

endmodule // arsc_reset_ctrl

`default_nettype wire

// *** arsc_conv_model.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "arsc_defines.svh"

// Converter front end: a sample every 4 cycles, bits that change each cycle
module arsc_conv_model (
  input wire logic core_clk,
  input wire logic sys_rst,
  output logic [1:0] conv_valid,
  output logic [`ARSC_SAMPLE_W-1:0] conv_data_0,
  output logic [`ARSC_SAMPLE_W-1:0] conv_data_1,
  output logic [1:0] mod_bit_in
);
  logic [7:0] cnt;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cnt <= 8'h00;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
  // Never zero, so a cleared data register stands out
  assign conv_valid = (cnt[1:0] == 2'h0) ? 2'h3 : 2'h0;
  assign conv_data_0 = {16'h00A5, cnt} | 24'h00_0001;
  assign conv_data_1 = {16'h005A, cnt} | 24'h00_0001;
  assign mod_bit_in = {cnt[0], ~cnt[0]};
endmodule // arsc_conv_model

`default_nettype wire

// *** arsc_reset_ctrl_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "arsc_defines.svh"

`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
  $display("Error %0t: got %0h exp %0h", $time, (g), (e)); end end

module arsc_reset_ctrl_bench;
  localparam int DIV = 8;
  logic core_clk, sys_rst, hard_reset_n, por_req, wr_en, rd_en;
  logic [`ARSC_ADDR_W-1:0] addr;
  logic [`ARSC_DATA_W-1:0] wr_data, rd_data, v;
  logic [1:0] conv_valid, mod_bit_in, data_ready, bs_out, bs_oe, bias;
  logic [`ARSC_SAMPLE_W-1:0] d0, d1;
  logic core_en, in_en, ref_en, mon_en, spi_rst, cmp_rst;
  logic [7:0] bits;
  int error_cnt = 0;
  int tests_run = 0;
  int c0, c1, n;

  arsc_conv_model u_conv (.core_clk(core_clk), .sys_rst(sys_rst),
    .conv_valid(conv_valid), .conv_data_0(d0), .conv_data_1(d1),
    .mod_bit_in(mod_bit_in));

  arsc_reset_ctrl #(.DR_DIV(DIV), .SINC_SETTLE(1)) u_dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .hard_reset_n(hard_reset_n),
    .por_req(por_req), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .conv_valid(conv_valid),
    .conv_data_0(d0), .conv_data_1(d1), .mod_bit_in(mod_bit_in),
    .data_ready(data_ready), .modulator_bitstream_out(bs_out),
    .modulator_bitstream_oe(bs_oe), .analog_bias_en(bias),
    .core_clk_en(core_en), .input_clk_en(in_en), .internal_ref_en(ref_en),
    .supply_monitor_en(mon_en), .serial_if_reset(spi_rst),
    .comparator_reset(cmp_rst));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
    // Gating outputs trail the register by one more edge
    repeat (3) @(posedge core_clk);
    #1;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    #1 d = rd_data;
  endtask

  task automatic count_dr(input int cyc);
    c0 = 0;
    c1 = 0;
    repeat (cyc) begin
      @(posedge core_clk);
      #1 c0 += int'(data_ready[0] === 1'b1);
      c1 += int'(data_ready[1] === 1'b1);
    end
  endtask

  task automatic tend(input string s);
    $display("Test %0s finished", s);
  endtask

  task automatic test_done;
    $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    error_cnt++;
    test_done;
  end

  initial begin
    sys_rst = 1'b1;
    hard_reset_n = 1'b1;
    por_req = 1'b0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 4'h0;
    wr_data = 32'h0000_0000;
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (4 * DIV) @(posedge core_clk);
    count_dr(8 * DIV);
    `CHK(c0, 8)
    `CHK(c1, 8)
    tend("startup");
    // Channel 1 lags channel 0 by the phase setting
    wr(`ARSC_REG_PHASE, 32'h0000_0003);
    n = 0;
    while (data_ready[0] !== 1'b1 && n < 100) begin
      @(posedge core_clk);
      #1 n++;
    end
    n = 0;
    while (data_ready[1] !== 1'b1 && n < 100) begin
      @(posedge core_clk);
      #1 n++;
    end
    `CHK(n, 3)
    tend("phase");
    // Soft reset of channel 0 with its bitstream on
    wr(`ARSC_REG_CONFIG, 32'h0000_0041);
    rd(`ARSC_REG_CONFIG, v);
    `CHK(v, 32'h0000_0041)
    rd(`ARSC_REG_DATA0, v);
    `CHK(v, 32'h0000_0000)
    rd(`ARSC_REG_PHASE, v);
    `CHK(v, 32'h0000_0003)
    count_dr(8 * DIV);
    `CHK(c0, 0)
    `CHK(c1, 8)
    `CHK(core_en, 1'b1)
    `CHK(bs_oe[0], 1'b1)
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      #1 bits[i] = bs_out[0];
    end
    // Period four with two ones: 0011 in whatever phase it is caught
    `CHK(bits[7:4], bits[3:0])
    `CHK($countones(bits[3:0]), 2)
    `CHK({bits[1:0] == 2'b11 || bits[2:1] == 2'b11 ||
      bits[3:2] == 2'b11 || {bits[0], bits[3]} == 2'b11}, 1'b1)
    tend("soft reset one");
    wr(`ARSC_REG_CONFIG, 32'h0000_0003);
    `CHK(core_en, 1'b0)
    `CHK(in_en, 1'b1)
    wr(`ARSC_REG_CONFIG, 32'h0000_0000);
    `CHK(core_en, 1'b1)
    tend("soft reset both");
    // Both shut down, then channel 0 back
    wr(`ARSC_REG_CONFIG, 32'h0000_000C);
    `CHK(in_en, 1'b0)
    `CHK(core_en, 1'b0)
    `CHK(bias, 2'b00)
    rd(`ARSC_REG_DATA1, v);
    `CHK(v, 32'h0000_0000)
    wr(`ARSC_REG_CONFIG, 32'h0000_0008);
    `CHK(bias, 2'b01)
    // Early results after leaving shutdown are not counted
    repeat (4 * DIV) @(posedge core_clk);
    count_dr(8 * DIV);
    `CHK(c0, 8)
    `CHK(c1, 0)
    tend("shutdown");
    wr(`ARSC_REG_CONFIG, 32'h0000_003C);
    `CHK({ref_en, mon_en, in_en}, 3'b000)
    rd(`ARSC_REG_STATUS, v);
    `CHK(v[3], 1'b1)
    rd(`ARSC_REG_CONFIG, v);
    `CHK(v, 32'h0000_003C)
    wr(`ARSC_REG_CONFIG, 32'h0000_002C);
    `CHK(mon_en, 1'b1)
    rd(`ARSC_REG_CONFIG, v);
    `CHK(v, 32'h0000_0000)
    tend("full shutdown");
    wr(`ARSC_REG_PHASE, 32'h0000_0005);
    @(posedge core_clk);
    hard_reset_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    #1 `CHK({bs_oe, spi_rst, cmp_rst}, 4'b0011)
    wr(`ARSC_REG_CONFIG, 32'h0000_0003);
    rd(`ARSC_REG_CONFIG, v);
    `CHK(v, 32'h0000_0000)
    @(posedge core_clk);
    hard_reset_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    rd(`ARSC_REG_PHASE, v);
    `CHK(v, 32'h0000_0000)
    wr(`ARSC_REG_CONFIG, 32'h0000_0088);
    rd(`ARSC_REG_CONFIG, v);
    `CHK(v, 32'h0000_0088)
    `CHK({spi_rst, cmp_rst, bs_oe}, 4'b0010)
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      #1 bits[i] = bs_out[1];
    end
    `CHK(bits[7:4], bits[3:0])
    `CHK($countones(bits[3:0]), 2)
    tend("hard reset");
    // Power-on request acts like the pin
    @(posedge core_clk);
    por_req <= 1'b1;
    repeat (4) @(posedge core_clk);
    #1 `CHK({bs_oe, spi_rst, cmp_rst}, 4'b0011)
    @(posedge core_clk);
    por_req <= 1'b0;
    repeat (4) @(posedge core_clk);
    rd(`ARSC_REG_CONFIG, v);
    `CHK(v, 32'h0000_0000)
    tend("power-on reset");
    test_done;
  end
endmodule // arsc_reset_ctrl_bench

`default_nettype wire
